// ### core/i2cm_core_if.sv
// signals shared between the master core and its two helpers
// assumes all three sit on the one system clock
interface i2cm_core_if;
    logic run;
    logic fastRate;
    logic tick;
    logic sclRaw;
    logic sdaRaw;
    logic sclSync;
    logic sdaSync;
    modport ctl (output run, fastRate, sclRaw, sdaRaw, input tick, sclSync, sdaSync);
    modport div (input run, fastRate, output tick);
    modport sync (input sclRaw, sdaRaw, output sclSync, sdaSync);
endinterface

// ### core/i2cm_master.sv
// register-driven two-wire bus master: command register, sequencer, pins
// assumes open-drain pads outside: oe high pulls the line low, pull-ups
// ------------------------------------------------------------
// rule summary
// ------------------------------------------------------------
// Function
// [RQ1] two selectable serial rates
// [RQ2] rates derived from system clock
// [RQ3] start: sda falls while scl high
// [RQ4] stop: sda rises while scl high
// [RQ5] sda changes only while scl low
// [RQ6] start only at cycle or byte boundary
// [RQ7] write sends two or three acked bytes
// [RQ8] 24-bit register shifted out msb first
// [RQ9] field0 bit0 selects read or write
// [RQ10] read: address, one byte, nack, stop
// [RQ11] received byte lands in field2
// [RQ12] completion raises done event to host
// [RQ13] flag reports all slave acks seen
// [RQ14] software may drive pins directly
// [RQ15] suppress_stop omits closing stop
// [RQ16] scl held low until next command
// [RQ17] chained single byte without start/stop
// [RQ18] saved direction persists when chaining
// [RQ19] on reads three-byte bit picks ack
// [RQ20] software clears suppress_stop on last command
// [RQ21] ninth clock carries acknowledge
//
// Chosen here: the register offsets and the address-and-strobe port.
module i2cm_master
    import i2cm_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [i2cm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [i2cm_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [i2cm_pkg::DATA_W-1:0] regRdata,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic transferDone
);
    import i2cm_pkg::*;

    i2cm_core_if cif ();
    i2cm_state_type state_ff;
    logic [1:0] q_ff;
    logic [3:0] bitIdx_ff;
    logic [1:0] bytesLeft_ff;
    logic rxByte_ff;
    logic dirRead_ff;
    logic fast_ff;
    logic threeOrAck_ff;
    logic noStop_ff;
    logic noStart_ff;
    logic [SH_W-1:0] sh_ff;
    logic nackSeen_ff;
    logic done_ff;
    logic ackFlag_ff;
    logic swEn_ff;
    logic swScl_ff;
    logic swSda_ff;
    logic sclOe_ff;
    logic sdaOe_ff;
    logic pinLow_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic busy;
    logic adv;
    logic cmdGo;
    logic cmdChain;
    logic dirNow;
    logic [1:0] bytesNow;
    logic lastBitEnd;
    logic doneSet;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    i2cm_rate_div u_div (
        .clock(clock),
        .resetn(resetn),
        .tk(cif.div)
    );

    i2cm_pin_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .ps(cif.sync)
    );

    assign busy = (state_ff == ST_START) || (state_ff == ST_BIT) || (state_ff == ST_STOP);
    assign cif.run = busy;
    assign cif.fastRate = fast_ff; // RQ1
    assign cif.sclRaw = sclIn;
    assign cif.sdaRaw = sdaIn;

    // a released scl that a slave still holds low stretches the high quarter
    assign adv = cif.tick && (q_ff != Q_HIGH || cif.sclSync);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // a command is only taken at a cycle boundary: idle or parked after a byte
    assign cmdGo = regWr && regAddr == REG_DATA && !swEn_ff
        && (state_ff == ST_IDLE || state_ff == ST_HOLD); // RQ6
    // chaining needs a parked bus; from idle the bits fall back to a full cycle
    // without suppress_stop the chained byte closes the set with a stop
    assign cmdChain = regWdata[CMD_NOS1B] && state_ff == ST_HOLD; // RQ17 RQ15
    assign dirNow = cmdChain ? dirRead_ff : regWdata[DIR_BIT]; // RQ9 RQ18

    always_comb begin
        if (cmdChain) begin
            bytesNow = BYTES_ONE; // RQ17
        end else if (dirNow) begin
            bytesNow = BYTES_TWO; // RQ10
        end else begin
            bytesNow = regWdata[CMD_THREE] ? BYTES_THREE : BYTES_TWO; // RQ7
        end
    end

    assign lastBitEnd = adv && q_ff == Q_LAST && state_ff == ST_BIT
        && bitIdx_ff == ACK_SLOT && bytesLeft_ff == BYTES_ONE;
    assign doneSet = (adv && q_ff == Q_LAST && state_ff == ST_STOP)
        || (lastBitEnd && noStop_ff);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            q_ff <= 2'h0;
            bitIdx_ff <= 4'h0;
            bytesLeft_ff <= 2'h0;
            rxByte_ff <= 1'b0;
        end else if (swEn_ff) begin
            state_ff <= ST_IDLE; // RQ14
            q_ff <= 2'h0;
        end else if (cmdGo) begin
            state_ff <= cmdChain ? ST_BIT : ST_START; // RQ3 RQ17
            q_ff <= 2'h0;
            bitIdx_ff <= 4'h0;
            bytesLeft_ff <= bytesNow;
            rxByte_ff <= cmdChain && dirNow;
        end else if (adv) begin
            q_ff <= q_ff + 2'h1;
            if (q_ff == Q_LAST) begin
                case (state_ff)
                    ST_START: begin
                        state_ff <= ST_BIT;
                        bitIdx_ff <= 4'h0;
                    end
                    ST_BIT: begin
                        if (bitIdx_ff == ACK_SLOT) begin // RQ21
                            bitIdx_ff <= 4'h0;
                            if (bytesLeft_ff == BYTES_ONE) begin
                                state_ff <= noStop_ff ? ST_HOLD : ST_STOP; // RQ15 RQ4
                            end else begin
                                bytesLeft_ff <= bytesLeft_ff - 2'h1;
                                // last byte of a normal read is the one received
                                rxByte_ff <= dirRead_ff && bytesLeft_ff == BYTES_TWO; // RQ10
                            end
                        end else begin
                            bitIdx_ff <= bitIdx_ff + 4'h1;
                        end
                    end
                    ST_STOP: state_ff <= ST_IDLE;
                    default: state_ff <= state_ff;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclOe_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end else if (swEn_ff) begin
            sclOe_ff <= !swScl_ff; // RQ14
            sdaOe_ff <= !swSda_ff;
        end else if (state_ff == ST_IDLE) begin
            sclOe_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end else if (state_ff == ST_HOLD) begin
            sclOe_ff <= 1'b1; // RQ16
        end else if (adv) begin
            case (state_ff)
                ST_START: begin
                    case (q_ff)
                        2'h0: sdaOe_ff <= 1'b0;
                        2'h1: sclOe_ff <= 1'b0;
                        2'h2: sdaOe_ff <= 1'b1; // RQ3
                        default: sclOe_ff <= 1'b1;
                    endcase
                end
                ST_BIT: begin
                    case (q_ff)
                        2'h0: begin
                            // data only moves in the low quarter
                            if (bitIdx_ff == ACK_SLOT) begin
                                sdaOe_ff <= rxByte_ff && threeOrAck_ff; // RQ19 RQ21
                            end else begin
                                sdaOe_ff <= !rxByte_ff && !sh_ff[SH_W-1]; // RQ5 RQ8
                            end
                        end
                        2'h1: sclOe_ff <= 1'b0;
                        2'h2: sclOe_ff <= 1'b0;
                        default: sclOe_ff <= 1'b1;
                    endcase
                end
                ST_STOP: begin
                    case (q_ff)
                        2'h0: sdaOe_ff <= 1'b1;
                        2'h1: sclOe_ff <= 1'b0;
                        2'h2: sdaOe_ff <= 1'b0; // RQ4
                        default: sdaOe_ff <= 1'b0;
                    endcase
                end
                default: sclOe_ff <= sclOe_ff;
            endcase
        end
    end

    // open-drain: the pads only ever pull low
    always_ff @(posedge clock) begin
        pinLow_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // data, command fields and status
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sh_ff <= '0;
            nackSeen_ff <= 1'b0;
            dirRead_ff <= 1'b0;
            fast_ff <= 1'b0;
            threeOrAck_ff <= 1'b0;
            noStop_ff <= 1'b0;
            noStart_ff <= 1'b0;
        end else if (cmdGo) begin
            sh_ff <= regWdata[SH_W-1:0];
            nackSeen_ff <= 1'b0;
            dirRead_ff <= dirNow; // RQ18
            fast_ff <= regWdata[CMD_RATE]; // RQ1
            threeOrAck_ff <= regWdata[CMD_THREE];
            noStop_ff <= regWdata[CMD_NOSTOP];
            noStart_ff <= regWdata[CMD_NOS1B];
        end else if (adv && state_ff == ST_BIT && q_ff == Q_HIGH) begin
            if (bitIdx_ff != ACK_SLOT) begin
                // one shift for both ways: a read byte ends up in field2
                sh_ff <= {sh_ff[SH_W-2:0], cif.sdaSync}; // RQ8 RQ11
            end else if (!rxByte_ff && cif.sdaSync) begin
                nackSeen_ff <= 1'b1; // RQ21
            end
        end
    end

    // set wins over a clear landing in the same cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            done_ff <= 1'b0;
            ackFlag_ff <= 1'b0;
        end else if (doneSet) begin
            done_ff <= 1'b1; // RQ12
            ackFlag_ff <= !nackSeen_ff; // RQ13
        end else if (regWr && regAddr == REG_STAT && regWdata[STAT_DONE]) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            {swSda_ff, swScl_ff, swEn_ff} <= SWCTL_RST;
        end else if (regWr && regAddr == REG_SWCTL) begin
            swEn_ff <= regWdata[SW_EN]; // RQ14
            swScl_ff <= regWdata[SW_SCL];
            swSda_ff <= regWdata[SW_SDA];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else if (regRd) begin
            case (regAddr)
                REG_DATA: rdata_ff <= {4'h0, noStart_ff, noStop_ff, threeOrAck_ff, fast_ff, sh_ff};
                REG_SWCTL: rdata_ff <= {29'h0, swSda_ff, swScl_ff, swEn_ff};
                REG_STAT: rdata_ff <= {27'h0, cif.sdaSync, cif.sclSync, busy, ackFlag_ff, done_ff};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign regRdata = rdata_ff;
    assign sclOe = sclOe_ff;
    assign sdaOe = sdaOe_ff;
    assign sclOut = pinLow_ff;
    assign sdaOut = pinLow_ff;
    assign transferDone = done_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [QCNT_W-1:0] gapCnt_ff;

    always_ff @(posedge clock) begin
        if (!resetn || !cif.run) begin
            gapCnt_ff <= '0;
        end else if (cif.tick) begin
            gapCnt_ff <= QCNT_W'(1);
        end else begin
            gapCnt_ff <= gapCnt_ff + 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    AST_QTR_RATE: assert property ( // RQ1
        cif.tick |-> gapCnt_ff == qtr_cycles(fast_ff))
        else $error("quarter-bit period does not match selected rate");

    AST_SDA_STABLE: assert property ( // RQ5
        (state_ff == ST_BIT && !sclOe_ff && !swEn_ff) |=> (swEn_ff || $stable(sdaOe_ff)))
        else $error("sda moved while scl released during a bit");

    AST_START_COND: assert property ( // RQ3
        ($rose(sdaOe_ff) && !sclOe_ff && !swEn_ff && !$past(swEn_ff))
        |-> ($past(state_ff) == ST_START && $past(q_ff) == Q_HIGH))
        else $error("sda pulled low with scl high outside a start");

    AST_STOP_COND: assert property ( // RQ4
        ($fell(sdaOe_ff) && !sclOe_ff && !swEn_ff && !$past(swEn_ff) && !$past(swEn_ff, 2))
        |-> $past(state_ff) == ST_STOP)
        else $error("sda released with scl high outside a stop");

    AST_MSB_FIRST: assert property ( // RQ8
        (adv && state_ff == ST_BIT && q_ff == 2'h0 && bitIdx_ff != ACK_SLOT && !rxByte_ff)
        |=> sdaOe_ff == !$past(sh_ff[SH_W-1]))
        else $error("transmitted bit is not the register msb");

    AST_WRITE_COUNT: assert property ( // RQ7
        (cmdGo && !cmdChain && !regWdata[DIR_BIT])
        |=> bytesLeft_ff == ($past(regWdata[CMD_THREE]) ? BYTES_THREE : BYTES_TWO))
        else $error("write byte count does not follow three-byte bit");

    AST_READ_ACK: assert property ( // RQ19
        (adv && state_ff == ST_BIT && q_ff == 2'h0 && bitIdx_ff == ACK_SLOT && rxByte_ff)
        |=> sdaOe_ff == threeOrAck_ff)
        else $error("master response to read byte is wrong");

    AST_END_CHOICE: assert property ( // RQ15
        ($past(state_ff) == ST_BIT && state_ff != ST_BIT && !$past(swEn_ff))
        |-> (state_ff == ST_HOLD) == noStop_ff)
        else $error("closing stop not governed by suppress_stop");

    AST_HOLD_LOW: assert property ( // RQ16
        (state_ff == ST_HOLD && !swEn_ff) |=> (sclOe_ff || swEn_ff) [*2])
        else $error("scl not held low while parked");

    AST_DONE_AFTER_STOP: assert property ( // RQ12
        (state_ff == ST_STOP && adv && q_ff == Q_LAST) |=> done_ff && state_ff == ST_IDLE)
        else $error("done event missing after stop");

    AST_SW_DRIVE: assert property ( // RQ14
        swEn_ff |=> sclOe_ff == !$past(swScl_ff) && sdaOe_ff == !$past(swSda_ff))
        else $error("software pin control not applied");

    COV_WRITE_DONE: cover property ($rose(done_ff) && !dirRead_ff && ackFlag_ff);
    COV_READ_DONE: cover property ($rose(done_ff) && dirRead_ff);
    COV_PARKED: cover property (state_ff == ST_HOLD ##1 cmdGo);
    COV_STRETCH: cover property (cif.tick && q_ff == Q_HIGH && !cif.sclSync);
endmodule // i2cm_master

// ### core/i2cm_pin_sync.sv
// two-stage synchronisers for the bus lines read back from the pins
// assumes the pins change without regard to the system clock
module i2cm_pin_sync
    import i2cm_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    i2cm_core_if.sync ps
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;

    // released bus idles high, so reset to high
    always_ff @(posedge clock) begin
        if (!resetn) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
        end else begin
            meta_ff <= {ps.sclRaw, ps.sdaRaw};
            sync_ff <= meta_ff;
        end
    end

    assign ps.sclSync = sync_ff[1];
    assign ps.sdaSync = sync_ff[0];
endmodule // i2cm_pin_sync

// ### core/i2cm_pkg.sv
// constants, field layout and state type of the two-wire bus master
// assumes a single 250 MHz clock and the plain register port of the top
package i2cm_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int RATE_SLOW_HHZ = 992;   // 99.2 kHz, in units of 100 Hz
    localparam int RATE_FAST_HHZ = 3968;  // 396.8 kHz, in units of 100 Hz
    localparam int HHZ = 100;
    localparam int QTR_PER_BIT = 4;
    localparam int QCNT_W = 10;
    localparam int SLOW_DIV = QTR_PER_BIT * HHZ * RATE_SLOW_HHZ;
    localparam int FAST_DIV = QTR_PER_BIT * HHZ * RATE_FAST_HHZ;
    // quarter bit is a least time, so round up
    localparam logic [QCNT_W-1:0] QTR_SLOW_CYC = QCNT_W'((CLK_HZ + SLOW_DIV - 1) / SLOW_DIV);
    localparam logic [QCNT_W-1:0] QTR_FAST_CYC = QCNT_W'((CLK_HZ + FAST_DIV - 1) / FAST_DIV);
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int SH_W = 24;
    localparam logic [ADDR_W-1:0] REG_DATA = 4'h0;
    localparam logic [ADDR_W-1:0] REG_SWCTL = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h8;
    localparam int DIR_BIT = 16;
    localparam int CMD_RATE = 24;
    localparam int CMD_THREE = 25;
    localparam int CMD_NOSTOP = 26;
    localparam int CMD_NOS1B = 27;
    localparam int SW_EN = 0;
    localparam int SW_SCL = 1;
    localparam int SW_SDA = 2;
    localparam int STAT_DONE = 0;
    localparam logic [2:0] SWCTL_RST = 3'h6;
    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] BYTES_ONE = 2'h1;
    localparam logic [1:0] BYTES_TWO = 2'h2;
    localparam logic [1:0] BYTES_THREE = 2'h3;
    localparam logic [1:0] Q_HIGH = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_BIT = 3'b010,
        ST_STOP = 3'b011,
        ST_HOLD = 3'b100
    } i2cm_state_type;

    function automatic logic [QCNT_W-1:0] qtr_cycles(input logic fast);
        return fast ? QTR_FAST_CYC : QTR_SLOW_CYC;
    endfunction
endpackage

// ### core/i2cm_rate_div.sv
// quarter-bit enable generator for the serial clock
// assumes run is held for the whole of a sequenced transfer
module i2cm_rate_div
    import i2cm_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    i2cm_core_if.div tk
);
    logic [QCNT_W-1:0] cnt_ff;
    logic tick_ff;

    // counted in system cycles, so a slower clock slows both rates alike
    always_ff @(posedge clock) begin // RQ2
        if (!resetn || !tk.run) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == qtr_cycles(tk.fastRate) - 1'b1) begin // RQ1
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tk.tick = tick_ff;
endmodule // i2cm_rate_div

// ### verification/i2cm_master_tb.sv
// self-checking bench of the two-wire master with one slave model
// assumes pull-ups on both lines; the slave never stretches scl
module i2cm_master_tb
    import i2cm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, regWr, regRd, sclOut, sclOe, sdaOut, sdaOe, transferDone;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, rxLog;
    logic slvOe, masterAck, sclW, sdaW;
    logic [7:0] txByte = 8'h00;
    logic [7:0] rxCount, c0;
    logic [3:0] nackIdx = 4'hf;
    int num_errors = 0;
    int check_count = 0;
    int numStart = 0;
    int numStop = 0;
    int s0, p0;
    assign sclW = !sclOe;
    assign sdaW = !(sdaOe | slvOe);
    i2cm_master i2cm_master_inst (.clock(clock), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .transferDone(transferDone));
    i2cm_slave_model i2cm_slave_model_inst (.scl(sclW), .sda(sdaW), .txByte(txByte),
        .nackIdx(nackIdx), .sdaOe(slvOe), .rxLog(rxLog), .rxCount(rxCount),
        .masterAck(masterAck));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(negedge sdaW) begin
        if (sclW === 1'b1)
            numStart++;
    end
    always @(posedge sdaW) begin
        if (sclW === 1'b1)
            numStop++;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        d = regRdata;
    endtask
    task automatic waitDone();
        int n;
        n = 0;
        while (transferDone !== 1'b1 && n < 25000) begin
            @(posedge clock);
            n++;
        end
        chk("transferDone", 32'h1, {31'h0, transferDone});
    endtask
    task automatic run(input logic [31:0] w);
        regWrite(REG_DATA, w);
        waitDone();
        regWrite(REG_STAT, 32'h1);
        repeat (2) @(posedge clock);
        chk("done cleared", 32'h0, {31'h0, transferDone});
    endtask
    task automatic snap();
        s0 = numStart;
        p0 = numStop;
        c0 = rxCount;
    endtask
    task automatic counts(input int st, input int sp, input int by);
        chk("starts", st, numStart - s0);
        chk("stops", sp, numStop - p0);
        chk("slave bytes", by, rxCount - c0);
    endtask
    // clock edges seen until scl goes low and then high again
    task automatic sclRise(output int n);
        n = 0;
        while (sclW !== 1'b0 && n < 9000) begin
            @(posedge clock);
            n++;
        end
        while (sclW !== 1'b1 && n < 9000) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic measure(output int per);
        int n;
        sclRise(n);
        sclRise(per);
    endtask
    task automatic swPins(input logic [31:0] w, input logic sclE, input logic sdaE);
        regWrite(REG_SWCTL, w);
        repeat (3) @(posedge clock);
        chk("scl oe", {31'h0, sclE}, {31'h0, sclOe});
        chk("sda oe", {31'h0, sdaE}, {31'h0, sdaOe});
        chk("pin out", 32'h0, {30'h0, sclOut, sdaOut});
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        regRead(REG_SWCTL, d);
        chk("swctl reset", 32'h6, d);
        regRead(REG_STAT, d);
        chk("status reset", 32'h18, d);
        regWrite(4'hc, 32'hffff_ffff);
        regRead(4'hc, d);
        chk("unmapped", 32'h0, d);
        $display("test regs done");
    endtask
    task automatic t_write();
        int per;
        logic [31:0] d;
        snap();
        regWrite(REG_DATA, 32'h03a0_1234);
        measure(per);
        chk("fast period", 4 * QTR_FAST_CYC, per);
        waitDone();
        regRead(REG_STAT, d);
        chk("ack flag", 32'h1, {31'h0, d[1]});
        regWrite(REG_STAT, 32'h1);
        counts(1, 1, 3);
        chk("bytes out", 32'h00a0_1234, {8'h0, rxLog[23:0]});
        $display("test write done");
    endtask
    task automatic t_nack();
        logic [31:0] d;
        nackIdx = 4'h1;
        snap();
        run(32'h01a0_5600);
        regRead(REG_STAT, d);
        chk("ack flag", 32'h0, {31'h0, d[1]});
        counts(1, 1, 2);
        nackIdx = 4'hf;
        $display("test nack done");
    endtask
    task automatic t_read();
        logic [31:0] d;
        txByte = 8'h5a;
        snap();
        run(32'h01a1_0000);
        regRead(REG_DATA, d);
        chk("read byte", 32'h5a, {24'h0, d[7:0]});
        chk("master nack", 32'h0, {31'h0, masterAck});
        counts(1, 1, 1);
        $display("test read done");
    endtask
    task automatic t_chain();
        logic [31:0] d;
        txByte = 8'h3c;
        snap();
        run(32'h05a0_1100);
        repeat (800) @(posedge clock);
        chk("scl parked", 32'h0, {31'h0, sclW});
        run(32'h0d77_0000);
        counts(1, 0, 3);
        chk("chained byte", 32'h77, {24'h0, rxLog[7:0]});
        run(32'h07a1_0000);
        regRead(REG_DATA, d);
        chk("acked read", 32'h3c, {24'h0, d[7:0]});
        chk("master ack", 32'h1, {31'h0, masterAck});
        txByte = 8'h45;
        run(32'h0900_0000);
        regRead(REG_DATA, d);
        chk("chained read", 32'h45, {24'h0, d[7:0]});
        chk("final nack", 32'h0, {31'h0, masterAck});
        counts(2, 1, 4);
        $display("test chain done");
    endtask
    task automatic t_slow();
        int per;
        logic [31:0] d;
        regWrite(REG_DATA, 32'h00a0_1100);
        measure(per);
        chk("slow period", 4 * QTR_SLOW_CYC, per);
        swPins(32'h5, 1'b1, 1'b0);
        swPins(32'h3, 1'b0, 1'b1);
        swPins(32'h6, 1'b0, 1'b0);
        regRead(REG_STAT, d);
        chk("busy after abort", 32'h0, {31'h0, d[2]});
        $display("test slow and software pins done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        t_regs();
        t_write();
        t_nack();
        t_read();
        t_chain();
        t_slow();
        end_sim();
    end
    // budget a little above the roughly 87k cycles the scenarios need
    initial begin
        #390000;
        num_errors++;
        $display("Error watchdog expired");
        end_sim();
    end
endmodule // i2cm_master_tb

// ### verification/i2cm_slave_model.sv
// two-wire slave model: acks written bytes, logs them, serves a read byte
// assumes the bench resolves both open-drain lines with pull-ups
module i2cm_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] txByte,
    input wire logic [3:0] nackIdx,
    output logic sdaOe,
    output logic [31:0] rxLog,
    output logic [7:0] rxCount,
    output logic masterAck
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = -1;
    logic [3:0] byteIdx = 4'h0;
    logic rd = 1'b0;
    logic first = 1'b0;
    logic [7:0] sh = 8'h00;
    initial begin
        sdaOe = 1'b0;
        rxLog = 32'h0;
        rxCount = 8'h0;
        masterAck = 1'b0;
    end
    // a start or repeated start restarts the frame
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            cnt = -1;
            byteIdx = 4'h0;
            rd = 1'b0;
            first = 1'b1;
            sdaOe = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (cnt >= 0 && cnt < 8 && !rd)
            sh = {sh[6:0], sda};
        if (cnt == 8 && rd)
            masterAck = !sda;
    end
    // drive only after scl falls, so the line is settled while scl is high
    always @(negedge scl) begin
        if (cnt == 8) begin
            if (first && !rd)
                rd = sh[0];
            else if (rd && !masterAck)
                rd = 1'b0;
            first = 1'b0;
        end
        cnt = (cnt == 8) ? 0 : cnt + 1;
        if (cnt == 8 && !rd) begin
            rxLog = {rxLog[23:0], sh};
            rxCount++;
            sdaOe = (byteIdx != nackIdx);
            byteIdx++;
        end else if (cnt < 8 && rd)
            sdaOe = !txByte[7 - cnt];
        else
            sdaOe = 1'b0;
    end
endmodule // i2cm_slave_model
